//--- core/rsa_rail_strobe.sv
`timescale 1ns/1ns
`default_nettype none
`include "rsa_map.svh"
// Operation
// - linear regulator field, slot six bits 3-0, reset 3h
// - slot seven at 0x26, reset 0x3
// - gp output c field bits 7-4, reset 0h
// - gp output a field bits 3-0, reset 3h
// - codes 3h-9h enable at matching strobe
// - code Ah enables at strobe ten
// - other codes leave output uncontrolled
// - writes need prior password unlock
// - strobes 1-2 only while seal intact
//
// how the block hangs together
// - two sequencer slots hold three 4-bit strobe fields; slot six keeps
//   only the linear regulator field in its low nibble, its upper nibble
//   belongs to another rail and is only stored and read back here
// - a field code picks the strobe at which its output switches on;
//   codes outside the strobe window leave the output to other control
// - the walk starts from idle on seq_start and steps one strobe per
//   enabled clock, ending in a done state that holds until reset
// - enables are sticky: once a strobe fires an output it stays on,
//   which is the intent of a power-up sequence (no rail bounces)
//
// hazards and limits
// - the seal flag comes from a pin in another domain, so it passes two
//   flip-flops before the start decision reads it; a change of the pin
//   therefore shows up three clocks later at the earliest
// - the write gate samples the unlock level in the same cycle as the
//   write strobe; a host that drops unlock one cycle early is refused
// - clock enable low freezes everything, the synchroniser included,
//   so a frozen sequence resumes exactly where it stopped
module rsa_rail_strobe (
  input  wire logic       core_clk,             // 100 MHz
  input  wire logic       resetn,               // synchronous, active low
  input  wire logic       clk_en,               // freezes all state when low
  input  wire logic [7:0] reg_addr,             // sub-address from the serial slave
  input  wire logic [7:0] reg_wdata,            // write data
  input  wire logic       reg_wr,               // one-cycle write strobe
  input  wire logic       unlocked,             // password unlock done, level sampled at each write
  output logic      [7:0] reg_rdata,            // read data, registered
  input  wire logic       seq_start,            // begin power-up sequence
  input  wire logic       freshness_seal_flag,  // seal still intact when high
  output logic      [3:0] strobe_now,           // strobe being issued, 0 when idle
  output logic            seq_busy,             // sequence running
  output logic            linear_regulator_en,  // rail enables, registered
  output logic            gp_out_a_en,
  output logic            gp_out_c_en
);
  typedef struct packed {
    logic [7:0]                  slot_six;
    logic [7:0]                  slot_seven;
    logic [7:0]                  rdata;
    logic [3:0]                  strobe;
    rsa_pkg::rsa_seq_state_type  st;
    logic                        ldo_en;
    logic                        gpa_en;
    logic                        gpc_en;
    logic                        seal_s1;  // seal pin, first sync stage
    logic                        seal_s2;  // seal pin, second sync stage
  } rsa_state_type;

  rsa_state_type s_q;  // registered state
  rsa_state_type s_d;  // next state

  // three identical decoders, one per output
  rsa_match_if m_ldo ();
  rsa_match_if m_gpa ();
  rsa_match_if m_gpc ();
  rsa_strobe_match u_ldo (.m(m_ldo));
  rsa_strobe_match u_gpa (.m(m_gpa));
  rsa_strobe_match u_gpc (.m(m_gpc));

  assign m_ldo.code   = s_q.slot_six[`RSA_LO_MSB:`RSA_LO_LSB];
  assign m_gpa.code   = s_q.slot_seven[`RSA_LO_MSB:`RSA_LO_LSB];
  assign m_gpc.code   = s_q.slot_seven[`RSA_HI_MSB:`RSA_HI_LSB];
  assign m_ldo.strobe = s_q.strobe;
  assign m_gpa.strobe = s_q.strobe;
  assign m_gpc.strobe = s_q.strobe;

  // next-state logic: register writes, readback and strobe walk
  // everything is computed from s_q, so the struct copy makes one clean
  // register stage and no field can be read before it is settled
  always_comb begin
    s_d = s_q;
    // seal pin is asynchronous: only the second stage feeds the walk
    s_d.seal_s1 = freshness_seal_flag;
    s_d.seal_s2 = s_q.seal_s1;
    // writes land only once the password is unlocked
    if (reg_wr && unlocked) begin
      if (reg_addr == `RSA_SLOT_SIX_ADDR) begin
        s_d.slot_six = reg_wdata;
      end else if (reg_addr == `RSA_SLOT_SEVEN_ADDR) begin
        s_d.slot_seven = reg_wdata;
      end
    end
    // readback; unmapped addresses read zero
    unique case (reg_addr)
      `RSA_SLOT_SIX_ADDR:   s_d.rdata = s_q.slot_six;
      `RSA_SLOT_SEVEN_ADDR: s_d.rdata = s_q.slot_seven;
      default:              s_d.rdata = 8'h00;
    endcase
    unique case (s_q.st)
      rsa_pkg::RSA_IDLE: begin
        if (seq_start) begin
          s_d.st     = rsa_pkg::RSA_STEP;
          // broken seal skips strobes 1 and 2; backup rails untouched here
          // synchronised seal decides once, at the start of the walk
          s_d.strobe = s_q.seal_s2 ? 4'h1 : `RSA_STROBE_FIRST;
        end
      end
      rsa_pkg::RSA_STEP: begin
        // enables are sticky so a rail never drops mid-sequence
        if (m_ldo.fire) s_d.ldo_en = 1'b1;
        if (m_gpa.fire) s_d.gpa_en = 1'b1;
        if (m_gpc.fire) s_d.gpc_en = 1'b1;
        if (s_q.strobe == `RSA_STROBE_LAST) begin
          s_d.st     = rsa_pkg::RSA_DONE;
          s_d.strobe = 4'h0;
        end else begin
          s_d.strobe = s_q.strobe + 4'h1;
        end
      end
      rsa_pkg::RSA_DONE: begin
        s_d.st = rsa_pkg::RSA_DONE;
      end
      default: begin
        s_d.st     = rsa_pkg::RSA_IDLE;
        s_d.strobe = 4'h0;
      end
    endcase
  end

  // state register with enable and synchronous reset
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_q.slot_six   <= `RSA_SLOT_SIX_RST;
      s_q.slot_seven <= `RSA_SLOT_SEVEN_RST;
      s_q.rdata      <= 8'h00;
      s_q.strobe     <= 4'h0;
      s_q.st         <= rsa_pkg::RSA_IDLE;
      s_q.ldo_en     <= 1'b0;
      s_q.gpa_en     <= 1'b0;
      s_q.gpc_en     <= 1'b0;
      // sync stages start low: a broken seal is the safe assumption
      s_q.seal_s1    <= 1'b0;
      s_q.seal_s2    <= 1'b0;
    end else if (clk_en) begin
      // clock enable low holds every field, the sync stages as well
      s_q <= s_d;
    end
  end

  // outputs straight from the state register; seq_busy is a decode of
  // the state code and so carries no extra flop delay
  assign reg_rdata           = s_q.rdata;
  assign strobe_now          = s_q.strobe;
  assign seq_busy            = (s_q.st == rsa_pkg::RSA_STEP);
  assign linear_regulator_en = s_q.ldo_en;
  assign gp_out_a_en         = s_q.gpa_en;
  assign gp_out_c_en         = s_q.gpc_en;
endmodule // rsa_rail_strobe
`default_nettype wire

//--- core/rsa_map.svh
`ifndef RSA_MAP_SVH
`define RSA_MAP_SVH
// register sub-addresses
`define RSA_SLOT_SIX_ADDR    8'h25
`define RSA_SLOT_SEVEN_ADDR  8'h26
// field positions
`define RSA_HI_MSB           7
`define RSA_HI_LSB           4
`define RSA_LO_MSB           3
`define RSA_LO_LSB           0
// reset values
`define RSA_SLOT_SIX_RST     8'h03
`define RSA_SLOT_SEVEN_RST   8'h03
// strobe code window
`define RSA_STROBE_FIRST     4'h3
`define RSA_STROBE_LAST      4'hA
`define RSA_STROBE_SEAL_LAST 4'h2
`endif

//--- core/rsa_pkg.sv
package rsa_pkg;
  typedef enum logic [1:0] {
    RSA_IDLE = 2'b00,
    RSA_STEP = 2'b01,
    RSA_DONE = 2'b10
  } rsa_seq_state_type;
endpackage

//--- core/rsa_match_if.sv
`timescale 1ns/1ns
`default_nettype none
// one decoder slot: field code in, current strobe in, enable hit out
interface rsa_match_if;
  logic [3:0] code;
  logic [3:0] strobe;
  logic       fire;
  logic       ctl;
  modport dec (input code, input strobe, output fire, output ctl);
  modport use_ (output code, output strobe, input fire, input ctl);
endinterface
`default_nettype wire

//--- core/rsa_strobe_match.sv
`timescale 1ns/1ns
`default_nettype none
`include "rsa_map.svh"
module rsa_strobe_match (
  rsa_match_if.dec m
);
  // codes 3h..Ah are sequencer controlled, the rest are left alone
  always_comb begin
    m.ctl  = (m.code >= `RSA_STROBE_FIRST) && (m.code <= `RSA_STROBE_LAST);
    m.fire = m.ctl && (m.code == m.strobe);
  end
endmodule // rsa_strobe_match
`default_nettype wire

//--- tb/rsa_rail_strobe_checker.sv
`timescale 1ns/1ns
`default_nettype none
// port-level watch on stepping, enables and read-back
module rsa_rail_strobe_checker (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       freshness_seal_flag,
  input wire logic [3:0] strobe_now,
  input wire logic       seq_busy,
  input wire logic       linear_regulator_en,
  input wire logic       gp_out_a_en,
  input wire logic       gp_out_c_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_step_up: assert property (clk_en && strobe_now inside {[1:9]}
    |=> strobe_now == $past(strobe_now) + 4'h1) else $error("step");
  chk_seal_skip: assert property ($rose(seq_busy) && !$past(freshness_seal_flag, 3)
    |-> strobe_now == 4'h3) else $error("skip");
  chk_seal_run: assert property ($rose(seq_busy) && $past(freshness_seal_flag, 3)
    |-> strobe_now == 4'h1) else $error("seal");
  chk_ten_last: assert property (clk_en && strobe_now == 4'hA
    |=> strobe_now == 4'h0 && !seq_busy) else $error("ten");
  chk_en_hold: assert property (gp_out_c_en |=> gp_out_c_en) else $error("hold");
  chk_lin_cause: assert property ($rose(linear_regulator_en)
    |-> $past(strobe_now) inside {[3:10]}) else $error("lin");
  chk_a_cause: assert property ($rose(gp_out_a_en)
    |-> $past(strobe_now) >= 4'h3) else $error("a");
  chk_free_addr: assert property ($past(clk_en) && !($past(reg_addr) inside {8'h25, 8'h26})
    |-> reg_rdata == 8'h00) else $error("free");
endmodule // rsa_rail_strobe_checker
bind rsa_rail_strobe rsa_rail_strobe_checker rsa_rail_strobe_checker_inst (.*);
`default_nettype wire

//--- tb/rsa_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// host side of the register port; changes only on falling edges
module rsa_host_model (
  input  wire logic       core_clk,
  output var  logic [7:0] reg_addr = 8'h00,
  output var  logic [7:0] reg_wdata = 8'h00,
  output var  logic       reg_wr = 1'b0,
  output var  logic       unlocked = 1'b0,
  input  wire logic [7:0] reg_rdata
);
  // seal flag is never read back, so no undefined value is trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic ul);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    unlocked = ul;
    @(negedge core_clk);
    reg_wr = 1'b0;
    unlocked = 1'b0;
    reg_wdata = ~v;
  endtask
  // read data is registered: one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge core_clk);
    reg_addr = a;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
endmodule // rsa_host_model
`default_nettype wire

//--- tb/rail_strobe_assignment_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rail_strobe_assignment_tb;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        seq_start = 1'b0;
  logic        freshness_seal_flag = 1'b0;
  logic        clk_en = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic        reg_wr, unlocked, seq_busy, linear_regulator_en, gp_out_a_en, gp_out_c_en;
  logic [3:0]  strobe_now, s;
  logic [31:0] rnd = 32'hA7D7;
  int          num_errors = 0;
  int          checked = 0;
  initial forever #5 core_clk = ~core_clk;
  rsa_rail_strobe rsa_rail_strobe_inst (.core_clk, .resetn, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .unlocked, .reg_rdata, .seq_start, .freshness_seal_flag,
    .strobe_now, .seq_busy, .linear_regulator_en, .gp_out_a_en, .gp_out_c_en);
  rsa_host_model rsa_host_model_inst (.core_clk, .reg_addr, .reg_wdata, .reg_wr,
    .unlocked, .reg_rdata);
  task chk(input string n, input logic [7:0] e, input logic [7:0] v);
    checked++;
    if (v !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, v);
    end
  endtask
  // a field code enables its output only inside the strobe window
  function automatic logic [7:0] ex(input logic [3:0] c);
    return {7'h00, c >= 4'h3 && c <= 4'hA};
  endfunction
  function automatic logic [31:0] nx(input logic [31:0] r);
    return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction
  task rst;
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
  endtask
  task results;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    results();
  end
  initial begin
    rst();
    rsa_host_model_inst.rd(8'h25, d);
    chk("six", 8'h03, d);
    rsa_host_model_inst.wr(8'h26, 8'h5A, 1'b0);
    rsa_host_model_inst.wr(8'h27, 8'h5A, 1'b1);
    rsa_host_model_inst.rd(8'h26, d);
    chk("seven", 8'h03, d);
    rsa_host_model_inst.rd(8'h27, d);
    chk("free", 8'h00, d);
    // every linear regulator code once, other fields random
    for (int i = 0; i < 16; i++) begin
      rnd = nx(rnd);
      // seal set early: the design sees it through a two-stage sync
      freshness_seal_flag = rnd[12];
      rst();
      rsa_host_model_inst.wr(8'h25, {rnd[11:8], 4'(i)}, 1'b1);
      rsa_host_model_inst.wr(8'h26, rnd[7:0], 1'b1);
      rsa_host_model_inst.rd(8'h26, d);
      chk("seven", rnd[7:0], d);
      seq_start = 1'b1;
      s = rnd[12] ? 4'h1 : 4'h3;
      @(negedge core_clk);
      // start stays high to show a running sequence ignores it
      for (int k = 0; k < 11 && s != 4'h0; k++) begin
        chk("strobe", {4'h0, s}, {4'h0, strobe_now});
        s = (s == 4'hA) ? 4'h0 : s + 4'h1;
        @(negedge core_clk);
      end
      chk("idle", 8'h00, {4'h0, strobe_now});
      chk("lin", ex(4'(i)), {7'h00, linear_regulator_en});
      chk("a", ex(rnd[3:0]), {7'h00, gp_out_a_en});
      chk("c", ex(rnd[7:4]), {7'h00, gp_out_c_en});
      seq_start = 1'b0;
    end
    // clock enable low mid-sequence must freeze strobe and linear regulator enable
    freshness_seal_flag = 1'b0;
    rst();
    seq_start = 1'b1;
    @(negedge core_clk);
    chk("run", 8'h03, {4'h0, strobe_now});
    clk_en = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("frozen", 8'h03, {4'h0, strobe_now});
    chk("frozen_en", 8'h00, {7'h00, linear_regulator_en});
    clk_en = 1'b1;
    @(negedge core_clk);
    chk("thaw", 8'h04, {4'h0, strobe_now});
    chk("thaw_en", 8'h01, {7'h00, linear_regulator_en});
    seq_start = 1'b0;
    results();
  end
endmodule // rail_strobe_assignment_tb
`default_nettype wire
